/* rtl/prefetch_limits_pkg.sv */
// prefetch_limits_pkg: offsets, field layout, reset values and decode helpers
// for the pre-fetch agent request limits register.
// assumes: included first in compile order; nothing imported by users.
`default_nettype none

package prefetch_limits_pkg;

    // ------------------------------------------------------------------
    // register placement
    // ------------------------------------------------------------------
    localparam logic [7:0] MEM_WINDOW_OFFSET = 8'h50;
    localparam logic [7:0] CFG_SPACE_OFFSET = 8'hE8;

    // ------------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------------
    localparam int COUNT_LSB = 8;
    localparam int COUNT_MSB = 11;
    localparam int POLICY_LSB = 6;
    localparam int POLICY_MSB = 7;
    localparam int LENGTH_LSB = 0;
    localparam int LENGTH_MSB = 3;

    // bits that hold storage; 15:12 and 5:4 are reserved
    localparam logic [15:0] WRITABLE_MASK = 16'h0FCF;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [15:0] REG_DEFAULT = 16'h0443;
    localparam logic [3:0] COUNT_DEFAULT = 4'h4;
    localparam logic [1:0] POLICY_DEFAULT = 2'h1;
    localparam logic [3:0] LENGTH_DEFAULT = 4'h3;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CACHE_NONE = 2'b00,
        CACHE_LIGHT = 2'b01,
        CACHE_FULL = 2'b10,
        CACHE_RSVD = 2'b11
    } completion_cache_policy_e;

    localparam logic [3:0] COUNT_DISABLED = 4'h0;
    localparam logic [3:0] COUNT_SINGLE = 4'h1;
    localparam logic [3:0] LENGTH_LAST_CODE = 4'h7;
    localparam logic [13:0] LENGTH_BASE_BYTES = 14'h0040;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // bytes per thread; reserved codes fall back to the smallest length
    function automatic logic [13:0] length_bytes(input logic [3:0] code);
        if (code > LENGTH_LAST_CODE) begin
            return LENGTH_BASE_BYTES;
        end
        return LENGTH_BASE_BYTES << code[2:0];
    endfunction

    // pre-fetch reads allowed after the initial read
    function automatic logic [3:0] extra_reads(input logic [3:0] count);
        if (count > COUNT_SINGLE) begin
            return count - COUNT_SINGLE;
        end
        return 4'h0;
    endfunction

    // the cache policies that allow pre-fetching at all
    function automatic logic policy_prefetches(input logic [1:0] policy);
        return (policy == CACHE_LIGHT) || (policy == CACHE_FULL);
    endfunction

endpackage

`default_nettype wire

/* rtl/prefetch_policy_decode.sv */
// prefetch_policy_decode: turns the stored register fields into the steering
// levels that the pre-fetch agent and the completion buffer follow.
// assumes: rst_sync_n already synchronised; fields arrive from flops.
`default_nettype none

module prefetch_policy_decode (
    input wire logic clk,
    input wire logic rst_sync_n,
    input wire logic [3:0] count_field,
    input wire logic [1:0] policy_field,
    input wire logic [3:0] length_field,
    output logic agent_enable,
    output logic single_buffer,
    output logic prefetch_enable,
    output logic [3:0] prefetch_reads,
    output logic discard_after_any,
    output logic discard_on_master_end,
    output logic keep_on_retry,
    output logic [13:0] read_length_bytes,
    output logic length_reserved
);

    // ------------------------------------------------------------------
    // request count steering
    // ------------------------------------------------------------------
    // zero stops the agent; one holds a thread to one buffer
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            agent_enable <= 1'b1;
            single_buffer <= 1'b0;
            prefetch_enable <= 1'b1;
            prefetch_reads <= prefetch_limits_pkg::extra_reads(prefetch_limits_pkg::COUNT_DEFAULT);
        end else begin
            agent_enable <= (count_field != prefetch_limits_pkg::COUNT_DISABLED); // RL2
            single_buffer <= (count_field == prefetch_limits_pkg::COUNT_SINGLE); // RL3
            prefetch_enable <= (count_field > prefetch_limits_pkg::COUNT_SINGLE)
                && prefetch_limits_pkg::policy_prefetches(policy_field); // RL3 RL5
            prefetch_reads <= prefetch_limits_pkg::extra_reads(count_field); // RL4
        end
    end

    // ------------------------------------------------------------------
    // completion cache policy
    // ------------------------------------------------------------------
    // reserved policy behaves like no caching
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            discard_after_any <= 1'b0;
            discard_on_master_end <= 1'b1;
            keep_on_retry <= 1'b1;
        end else begin
            discard_after_any <= !prefetch_limits_pkg::policy_prefetches(policy_field); // RL5
            discard_on_master_end <= (policy_field != prefetch_limits_pkg::CACHE_FULL); // RL6 RL7
            keep_on_retry <= prefetch_limits_pkg::policy_prefetches(policy_field); // RL6 RL7
        end
    end

    // ------------------------------------------------------------------
    // read length per thread
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            read_length_bytes <= prefetch_limits_pkg::length_bytes(
                prefetch_limits_pkg::LENGTH_DEFAULT);
            length_reserved <= 1'b0;
        end else begin
            read_length_bytes <= prefetch_limits_pkg::length_bytes(length_field); // RL8
            length_reserved <= (length_field > prefetch_limits_pkg::LENGTH_LAST_CODE); // RL8
        end
    end

endmodule

`default_nettype wire

/* rtl/prefetch_request_limits.sv */
// prefetch_request_limits: one 16-bit control register reached through the
// memory window and through configuration space, driving pre-fetch steering.
// assumes: both access ports and the two reset inputs are synchronous to clk.
//
// Contract
// [RL1] reserved bits 15:12 and 5:4 always read back as zero
// [RL2] request count zero switches the pre-fetch agent off entirely
// [RL3] request count one keeps a thread to one buffer, no pre-fetch
// [RL4] counts two to fifteen allow initial read plus count minus one pre-fetches
// [RL5] policy 00 disables pre-fetch and drops leftovers after any data; 11 reserved
// [RL6] policy 01 pre-fetches; drops on master end, keeps on bridge retry
// [RL7] policy 10 pre-fetches; keeps leftovers on master end and on retry
// [RL8] length code selects 64 bytes doubling to 8 Kbytes; codes above seven reserved
// [RL9] count field returns to default on fundamental, global or power-on reset
// [RL10] register reads 0443h after reset
// [RL11] one storage seen at window offset 50h and configuration offset E8h
`default_nettype none

module prefetch_request_limits (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fundamental_reset_in,
    input wire logic global_reset_in,
    input wire logic [7:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [1:0] mem_be,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_rvalid,
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [1:0] cfg_be,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic agent_enable,
    output logic single_buffer,
    output logic prefetch_enable,
    output logic [3:0] prefetch_reads,
    output logic discard_after_any,
    output logic discard_on_master_end,
    output logic keep_on_retry,
    output logic [13:0] read_length_bytes,
    output logic length_reserved
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;
    logic rst_sync_n;

    // assert at once, release two edges later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign rst_sync_n = rst_sync_q;

    // ------------------------------------------------------------------
    // address decode and byte merge
    // ------------------------------------------------------------------
    logic mem_hit;
    logic cfg_hit;
    logic mem_wr_hit;
    logic cfg_wr_hit;
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic [1:0] policy_q;
    logic [1:0] policy_d;
    logic [3:0] length_q;
    logic [3:0] length_d;
    logic [15:0] reg_view;
    logic [15:0] wr_data;
    logic [1:0] wr_be;
    logic field_reset;

    // both paths address the same storage
    assign mem_hit = (mem_addr == prefetch_limits_pkg::MEM_WINDOW_OFFSET); // RL11
    assign cfg_hit = (cfg_addr == prefetch_limits_pkg::CFG_SPACE_OFFSET); // RL11
    assign mem_wr_hit = mem_wr && mem_hit;
    assign cfg_wr_hit = cfg_wr && cfg_hit;
    assign field_reset = fundamental_reset_in || global_reset_in;

    // configuration write wins when both paths write in one cycle
    assign wr_data = cfg_wr_hit ? cfg_wdata : mem_wdata;
    assign wr_be = cfg_wr_hit ? cfg_be : mem_be;

    // reserved bits are never stored, so they read as zero
    assign reg_view = {4'h0, count_q, policy_q, 2'b00, length_q}; // RL1

    // next field values from the chosen write
    always_comb begin
        count_d = count_q;
        policy_d = policy_q;
        length_d = length_q;
        if (mem_wr_hit || cfg_wr_hit) begin
            if (wr_be[1]) begin
                count_d = wr_data[prefetch_limits_pkg::COUNT_MSB
                    :prefetch_limits_pkg::COUNT_LSB];
            end
            if (wr_be[0]) begin
                policy_d = wr_data[prefetch_limits_pkg::POLICY_MSB
                    :prefetch_limits_pkg::POLICY_LSB];
                length_d = wr_data[prefetch_limits_pkg::LENGTH_MSB
                    :prefetch_limits_pkg::LENGTH_LSB];
            end
        end
    end

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // count field also falls back on the bridge-level resets
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            count_q <= prefetch_limits_pkg::COUNT_DEFAULT; // RL10
        end else if (field_reset) begin
            count_q <= prefetch_limits_pkg::COUNT_DEFAULT; // RL9
        end else begin
            count_q <= count_d; // RL11
        end
    end

    // policy and length fields, power-on reset only
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            policy_q <= prefetch_limits_pkg::POLICY_DEFAULT; // RL10
            length_q <= prefetch_limits_pkg::LENGTH_DEFAULT; // RL10
        end else begin
            policy_q <= policy_d; // RL11
            length_q <= length_d; // RL11
        end
    end

    // ------------------------------------------------------------------
    // read answers
    // ------------------------------------------------------------------
    // window read: one cycle later, zero for an unmapped offset
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mem_rdata <= 16'h0000;
            mem_rvalid <= 1'b0;
        end else begin
            mem_rvalid <= mem_rd;
            mem_rdata <= (mem_rd && mem_hit) ? reg_view : 16'h0000; // RL1 RL11
        end
    end

    // configuration read: same timing, same storage
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cfg_rdata <= 16'h0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            cfg_rdata <= (cfg_rd && cfg_hit) ? reg_view : 16'h0000; // RL1 RL11
        end
    end

    // ------------------------------------------------------------------
    // steering decode
    // ------------------------------------------------------------------
    prefetch_policy_decode u_decode (
        .clk(clk),
        .rst_sync_n(rst_sync_n),
        .count_field(count_q),
        .policy_field(policy_q),
        .length_field(length_q),
        .agent_enable(agent_enable),
        .single_buffer(single_buffer),
        .prefetch_enable(prefetch_enable),
        .prefetch_reads(prefetch_reads),
        .discard_after_any(discard_after_any),
        .discard_on_master_end(discard_on_master_end),
        .keep_on_retry(keep_on_retry),
        .read_length_bytes(read_length_bytes),
        .length_reserved(length_reserved)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // reserved bits of any answer stay zero
    property p_rsvd_zero;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_rvalid || cfg_rvalid) |->
            (mem_rdata[15:12] == 4'h0) && (mem_rdata[5:4] == 2'b00)
            && (cfg_rdata[15:12] == 4'h0) && (cfg_rdata[5:4] == 2'b00);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits read nonzero"); // RL1

    // count zero leaves the agent off on the next cycle
    property p_agent_off;
        @(posedge clk) disable iff (!rst_sync_n)
        (count_q == 4'h0) |=> !agent_enable && !prefetch_enable;
    endproperty
    a_agent_off: assert property (p_agent_off) else $error("agent on with zero count"); // RL2

    // count one: single buffer, no pre-fetch
    property p_single;
        @(posedge clk) disable iff (!rst_sync_n)
        (count_q == 4'h1) |=> single_buffer && agent_enable && !prefetch_enable;
    endproperty
    a_single: assert property (p_single) else $error("count one not single buffer"); // RL3

    // pre-fetch budget is count minus one
    property p_budget;
        @(posedge clk) disable iff (!rst_sync_n)
        (count_q >= 4'h2) |=> (prefetch_reads == $past(count_q) - 4'h1) && !single_buffer;
    endproperty
    a_budget: assert property (p_budget) else $error("pre-fetch budget wrong"); // RL4

    // no caching: pre-fetch off, drop after any data
    property p_no_cache;
        @(posedge clk) disable iff (!rst_sync_n)
        (policy_q == 2'b00) |=> !prefetch_enable && discard_after_any && !keep_on_retry;
    endproperty
    a_no_cache: assert property (p_no_cache) else $error("no caching policy wrong"); // RL5

    // light caching: drop on master end, keep on retry
    property p_light;
        @(posedge clk) disable iff (!rst_sync_n)
        (policy_q == 2'b01) |=> discard_on_master_end && keep_on_retry && !discard_after_any
            && (prefetch_enable == ($past(count_q) >= 4'h2));
    endproperty
    a_light: assert property (p_light) else $error("light caching policy wrong"); // RL6

    // full caching: keep in both cases
    property p_full;
        @(posedge clk) disable iff (!rst_sync_n)
        (policy_q == 2'b10) |=> !discard_on_master_end && keep_on_retry && !discard_after_any;
    endproperty
    a_full: assert property (p_full) else $error("full caching policy wrong"); // RL7

    // length doubles from 64 bytes per code step
    property p_length;
        @(posedge clk) disable iff (!rst_sync_n)
        (length_q <= 4'h7) |=> (read_length_bytes == (14'h0040 << $past(length_q[2:0])))
            && !length_reserved;
    endproperty
    a_length: assert property (p_length) else $error("read length wrong"); // RL8

    // bridge reset puts the count back to four, other fields kept
    property p_count_reset;
        @(posedge clk) disable iff (!rst_sync_n)
        field_reset |=> (count_q == 4'h4) && (policy_q == $past(policy_d))
            && (length_q == $past(length_d));
    endproperty
    a_count_reset: assert property (p_count_reset) else $error("count not restored"); // RL9

    // first cycle out of reset shows the default value
    property p_default;
        @(posedge clk) disable iff (!rst_sync_n)
        !$past(rst_sync_n) |-> (reg_view == 16'h0443);
    endproperty
    a_default: assert property (p_default) else $error("reset value not 0443h"); // RL10

    // full window write is seen by a configuration read right after
    property p_alias;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_wr_hit && (mem_be == 2'b11) && !cfg_wr && !field_reset) ##1
            (cfg_rd && cfg_hit) |=> (cfg_rdata == ($past(mem_wdata, 2) & 16'h0FCF));
    endproperty
    a_alias: assert property (p_alias) else $error("alias write not visible"); // RL11

    // both ports read the same storage in the same cycle
    property p_same_view;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_rd && mem_hit && cfg_rd && cfg_hit) |=> (mem_rdata == cfg_rdata) && mem_rvalid;
    endproperty
    a_same_view: assert property (p_same_view) else $error("ports disagree"); // RL11

    // bridge reset shows in the decode two cycles later
    property p_reset_decode;
        @(posedge clk) disable iff (!rst_sync_n)
        field_reset |=> ##1 agent_enable && !single_buffer
            && (prefetch_reads == 4'h3);
    endproperty
    a_reset_decode: assert property (p_reset_decode) else $error("bad reset decode"); // RL9

    // unmapped offsets answer zero
    property p_unmapped;
        @(posedge clk) disable iff (!rst_sync_n)
        (mem_rd && !mem_hit) |=> mem_rvalid
            && (mem_rdata == 16'h0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero"); // RL11

endmodule

`default_nettype wire

/* verif/pci_read_master_model.sv */
// pci_read_master_model: far-side master that opens one read thread per
// start pulse and counts the reads that the bridge steering grants it.
// assumes: steering outputs have settled before thread_start is raised.
`default_nettype none

module pci_read_master_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic thread_start,
    input wire logic agent_enable,
    input wire logic prefetch_enable,
    input wire logic [3:0] prefetch_reads,
    output logic [4:0] thread_reads
);
    timeunit 1ns;
    timeprecision 1ns;

    // initial read plus whatever pre-fetch reads the steering allows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            thread_reads <= 5'h00;
        end else if (thread_start) begin
            thread_reads <= (agent_enable && prefetch_enable) ?
                            5'(prefetch_reads) + 5'h01 : 5'h01;
        end
    end
endmodule

`default_nettype wire

/* verif/testbench.sv */
// testbench: drives the request limits register through both access ports
// and checks read-back, steering outputs and the far-side thread count.
// assumes: design and package compiled first; one 20 MHz clock.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic clk, rst_n, fundamental_reset_in, global_reset_in, thread_start;
    logic mem_wr, mem_rd, cfg_wr, cfg_rd, mem_rvalid, cfg_rvalid;
    logic [7:0] bus_addr, cfg_addr;
    logic [1:0] bus_be;
    logic [15:0] bus_wdata, mem_rdata, cfg_rdata, steer_now;
    logic agent_enable, single_buffer, prefetch_enable, discard_after_any;
    logic discard_on_master_end, keep_on_retry, length_reserved;
    logic [3:0] prefetch_reads;
    logic [13:0] read_length_bytes;
    logic [4:0] thread_reads;
    int num_errors = 0;
    int total_checks = 0;

    // steering flags packed for one comparison
    assign steer_now = {5'h00, agent_enable, single_buffer, prefetch_enable, prefetch_reads,
                        discard_after_any, discard_on_master_end, keep_on_retry,
                        length_reserved};

    prefetch_request_limits u_prefetch_request_limits (
        .clk(clk), .rst_n(rst_n), .fundamental_reset_in(fundamental_reset_in),
        .global_reset_in(global_reset_in), .mem_addr(bus_addr), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_be(bus_be), .mem_wdata(bus_wdata), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_be(bus_be), .cfg_wdata(bus_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .agent_enable(agent_enable),
        .single_buffer(single_buffer), .prefetch_enable(prefetch_enable),
        .prefetch_reads(prefetch_reads), .discard_after_any(discard_after_any),
        .discard_on_master_end(discard_on_master_end), .keep_on_retry(keep_on_retry),
        .read_length_bytes(read_length_bytes), .length_reserved(length_reserved)
    );

    pci_read_master_model u_pci_read_master_model (
        .clk(clk), .rst_n(rst_n), .thread_start(thread_start),
        .agent_enable(agent_enable), .prefetch_enable(prefetch_enable),
        .prefetch_reads(prefetch_reads), .thread_reads(thread_reads)
    );

    // free-running 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // expectations worked out from the field encodings
    // ------------------------------------------------------------------
    function automatic logic [15:0] exp_steer(input logic [15:0] r);
        logic [3:0] c;
        logic [1:0] p;
        c = r[11:8];
        p = r[7:6];
        return {5'h00, c != 4'h0, c == 4'h1, (c >= 4'h2) && (p == 2'b01 || p == 2'b10),
                (c >= 4'h2) ? c - 4'h1 : 4'h0, p == 2'b00 || p == 2'b11, p != 2'b10,
                p == 2'b01 || p == 2'b10, r[3:0] > 4'h7};
    endfunction

    function automatic logic [13:0] exp_len(input logic [3:0] code);
        return (code > 4'h7) ? 14'h0040 : 14'h0040 << code;
    endfunction

    function automatic logic [4:0] exp_reads(input logic [15:0] r);
        logic on;
        on = (r[11:8] >= 4'h2) && (r[7:6] == 2'b01 || r[7:6] == 2'b10);
        return on ? {1'b0, r[11:8]} : 5'h01;
    endfunction

    // ------------------------------------------------------------------
    // compare, bus and closing tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: register %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_out(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: steering %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask

    // one-cycle write strobe on the chosen port
    task automatic bus_write(input logic cfg, input logic [7:0] a, input logic [1:0] be,
                             input logic [15:0] d);
        @(posedge clk);
        bus_addr <= a;
        cfg_addr <= a;
        bus_be <= be;
        bus_wdata <= d;
        mem_wr <= !cfg;
        cfg_wr <= cfg;
        @(posedge clk);
        mem_wr <= 1'b0;
        cfg_wr <= 1'b0;
    endtask

    // one-cycle read strobe, answer awaited under a bound
    task automatic check_read(input logic cfg, input logic [7:0] a, input logic [15:0] exp);
        int n;
        @(posedge clk);
        bus_addr <= a;
        cfg_addr <= a;
        mem_rd <= !cfg;
        cfg_rd <= cfg;
        @(posedge clk);
        mem_rd <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        n = 0;
        while ((cfg ? cfg_rvalid : mem_rvalid) !== 1'b1) begin
            n++;
            if (n > 4) begin
                num_errors++;
                $display("wrong value at %0t: read never answered", $time);
                final_report();
            end
            @(posedge clk);
            #1;
        end
        check_reg(cfg ? cfg_rdata : mem_rdata, exp);
    endtask

    // full write, then steering, thread count and read-back on the other port
    task automatic apply(input logic cfg, input logic [15:0] v);
        logic [15:0] kept;
        kept = v & 16'h0FCF;
        bus_write(cfg, cfg ? 8'hE8 : 8'h50, 2'b11, v);
        repeat (2) @(posedge clk);
        thread_start <= 1'b1;
        @(posedge clk);
        thread_start <= 1'b0;
        #1;
        check_out(steer_now, exp_steer(kept));
        check_out({2'b00, read_length_bytes}, {2'b00, exp_len(kept[3:0])});
        check_out({11'h000, thread_reads}, {11'h000, exp_reads(kept)});
        check_read(!cfg, cfg ? 8'h50 : 8'hE8, kept);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        fundamental_reset_in = 1'b0;
        global_reset_in = 1'b0;
        thread_start = 1'b0;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        bus_addr = 8'h00;
        cfg_addr = 8'h00;
        bus_be = 2'b00;
        bus_wdata = 16'h0000;
        do_reset();
        check_read(1'b0, 8'h50, 16'h0443);
        check_read(1'b1, 8'hE8, 16'h0443);
        check_out(steer_now, exp_steer(16'h0443));
        $display("test reset values done");
        for (int c = 0; c < 16; c++) apply(1'(c), {4'hF, 4'(c), 8'hB3});
        $display("test request counts done");
        for (int p = 0; p < 4; p++) apply(1'(p), {8'h04, 2'(p), 6'h03});
        $display("test cache policies done");
        for (int n = 0; n < 16; n++) apply(1'(n), 16'hF470 | 16'(n));
        $display("test read lengths done");
        bus_write(1'b0, 8'h50, 2'b01, 16'h0A81);
        check_read(1'b1, 8'hE8, 16'h0481);
        bus_write(1'b1, 8'hE8, 2'b10, 16'hFA00);
        check_read(1'b0, 8'h50, 16'h0A81);
        $display("test byte enables done");
        for (int i = 0; i < 2; i++) begin
            bus_write(1'b0, 8'h50, 2'b11, 16'h0A81);
            @(posedge clk);
            fundamental_reset_in <= (i == 0);
            global_reset_in <= (i == 1);
            @(posedge clk);
            fundamental_reset_in <= 1'b0;
            global_reset_in <= 1'b0;
            check_read(1'b1, 8'hE8, 16'h0481);
        end
        $display("test bridge resets done");
        bus_write(1'b0, 8'h52, 2'b11, 16'hFFFF);
        check_read(1'b0, 8'h52, 16'h0000);
        check_read(1'b1, 8'h50, 16'h0000);
        check_read(1'b0, 8'h50, 16'h0481);
        $display("test unmapped offsets done");
        bus_write(1'b0, 8'h50, 2'b11, 16'hF5F6);
        cfg_addr <= 8'hE8;
        mem_rd <= 1'b1;
        cfg_rd <= 1'b1;
        @(posedge clk);
        mem_rd <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        check_reg(mem_rdata, 16'h05C6);
        check_reg(cfg_rdata, 16'h05C6);
        check_out({14'h0000, mem_rvalid, cfg_rvalid}, 16'h0003);
        @(posedge clk);
        #1;
        check_out({14'h0000, mem_rvalid, cfg_rvalid}, 16'h0000);
        $display("test same-cycle reads done");
        bus_write(1'b1, 8'hE8, 2'b11, 16'h0A81);
        do_reset();
        check_read(1'b0, 8'h50, 16'h0443);
        check_out(steer_now, exp_steer(16'h0443));
        $display("test mid-run reset done");
        final_report();
    end
endmodule

`default_nettype wire
